// ==== prs_top.sv ====
// Power-on and system reset sequencer
// Notes on behaviour
// - Sense low: hold reset, tristate all I/O
// - Sense rising edge releases primary PLL
// - Hold internal resets 60 ms after sense
// - Delay expiry releases internal resets once supply_ok_warning_i is high, boot starts
// - Power-up gives normal mode defaults
// - Same defaults on every warm reset
// - Power-up, warning, watchdog are reset sources
// - Warning parks mirrors, then resets
// - Any system reset tristates GPIO
// - Primary PLL reset only on power-up
// - Only processor resets released after reset
// - Mirror-link PLL powered down on reset
// - LVDS powered down, tristated, held in reset
// - External resets held until firmware release
// - Processor full rate, boots from flash
// - Mirror clocking brought up in order
// - Divider release enables clocks, then external resets
// - LVDS reset released after power confirmed
module prs_top #(
  parameter int unsigned SENSE_DELAY = prs_pkg::SENSE_DELAY_CYC,
  parameter int unsigned PARK_TIMEOUT = prs_pkg::PARK_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Power monitor pins
  input wire logic power_on_sense_i,
  input wire logic supply_ok_warning_i,
  // Watchdog and mirror park handshake
  input wire logic watchdog_timeout_i,
  input wire logic park_done_i,
  // Firmware requests
  input wire prs_pkg::prs_fw_req_t fw_req_i,
  // Outputs
  output prs_pkg::prs_ctl_t ctl_o,
  output logic park_req_o,
  output logic [prs_pkg::GPIO_W-1:0] gpio_oe_o
);

  localparam int CNT_W = $clog2(SENSE_DELAY + 1);
  localparam int PARK_W = $clog2(PARK_TIMEOUT + 1);

  logic sense_s;
  logic warn_s;
  logic sense_d_r;
  logic sense_rise;
  prs_pkg::prs_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [PARK_W-1:0] park_cnt_r;
  prs_pkg::prs_ctl_t ctl_r;
  logic park_req_r;
  logic [prs_pkg::GPIO_W-1:0] gpio_oe_r;
  logic sys_rst;
  logic warn_d_r;
  logic warn_fall;
  logic run_or_park;
  logic pll_rst_r;
  logic cpu_rst_r;
  logic periph_rst_r;
  logic other_rst_r;
  logic mlink_pd_r;
  logic div_rst_r;
  logic mclk_en_r;
  logic lvds_pd_r;
  logic lvds_rst_r;
  logic lvds_oe_r;
  logic ext_rst_r;
  logic io_oe_r;
  logic boot_flash_r;
  logic full_rate_r;

  // Pin synchronisers
  prs_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i({power_on_sense_i, supply_ok_warning_i}),
    .sync_o({sense_s, warn_s})
  );

  // Edge detect on synchronised levels
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sense_d_r <= 1'b0;
      warn_d_r <= 1'b0;
    end else begin
      sense_d_r <= sense_s;
      warn_d_r <= warn_s;
    end
  end

  assign sense_rise = sense_s && !sense_d_r;
  assign warn_fall = !warn_s && warn_d_r && (state_r == prs_pkg::PRS_RUN);

  // Warm system reset: watchdog or park complete
  assign sys_rst = (state_r == prs_pkg::PRS_RUN && watchdog_timeout_i) ||
                   (state_r == prs_pkg::PRS_PARK &&
                    (park_done_i || park_cnt_r == PARK_W'(PARK_TIMEOUT)));

  // Processor and mirror link stay up until parking ends
  assign run_or_park = (state_r == prs_pkg::PRS_RUN) ||
                       (state_r == prs_pkg::PRS_PARK);

  // Sequencer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r <= prs_pkg::PRS_OFF;
    end else if (!sense_s) begin
      state_r <= prs_pkg::PRS_OFF;
    end else begin
      case (state_r)
        prs_pkg::PRS_OFF: begin
          if (sense_rise) begin
            state_r <= prs_pkg::PRS_PLL_WAIT;
          end
        end
        prs_pkg::PRS_PLL_WAIT: begin
          if (cnt_r == CNT_W'(SENSE_DELAY - 1)) begin
            state_r <= prs_pkg::PRS_SYSRST;
          end
        end
        prs_pkg::PRS_RUN: begin
          if (warn_fall) begin
            state_r <= prs_pkg::PRS_PARK;
          end else if (watchdog_timeout_i) begin
            state_r <= prs_pkg::PRS_SYSRST;
          end
        end
        prs_pkg::PRS_PARK: begin
          if (sys_rst) begin
            state_r <= prs_pkg::PRS_SYSRST;
          end
        end
        prs_pkg::PRS_SYSRST: begin
          if (warn_s) begin
            state_r <= prs_pkg::PRS_RUN;
          end
        end
        default: begin
          state_r <= prs_pkg::PRS_OFF;
        end
      endcase
    end
  end

  // Post-sense delay counter
  always_ff @(posedge core_clk_i) begin
    if (srst_i || state_r != prs_pkg::PRS_PLL_WAIT) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Park timeout counter
  always_ff @(posedge core_clk_i) begin
    if (srst_i || state_r != prs_pkg::PRS_PARK) begin
      park_cnt_r <= '0;
    end else if (park_cnt_r != PARK_W'(PARK_TIMEOUT)) begin
      park_cnt_r <= park_cnt_r + PARK_W'(1);
    end
  end

  // Park request
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      park_req_r <= 1'b0;
    end else begin
      park_req_r <= sense_s && state_r == prs_pkg::PRS_PARK && !sys_rst;
    end
  end

  // Primary PLL and processor resets
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !sense_s || state_r == prs_pkg::PRS_OFF) begin
      pll_rst_r <= prs_pkg::RST_ASSERTED;
      cpu_rst_r <= prs_pkg::RST_ASSERTED;
      periph_rst_r <= prs_pkg::RST_ASSERTED;
      full_rate_r <= 1'b1;
      boot_flash_r <= 1'b1;
    end else begin
      pll_rst_r <= 1'b0;
      cpu_rst_r <= !run_or_park;
      periph_rst_r <= !run_or_park;
      full_rate_r <= 1'b1;
      boot_flash_r <= 1'b1;
    end
  end

  // Firmware-released resets, defaults forced outside run and park
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !sense_s || !run_or_park || sys_rst) begin
      other_rst_r <= prs_pkg::RST_ASSERTED;
      mlink_pd_r <= 1'b1;
      div_rst_r <= prs_pkg::RST_ASSERTED;
      mclk_en_r <= 1'b0;
      lvds_pd_r <= 1'b1;
      lvds_rst_r <= prs_pkg::RST_ASSERTED;
      lvds_oe_r <= 1'b0;
      ext_rst_r <= prs_pkg::RST_ASSERTED;
    end else if (state_r == prs_pkg::PRS_RUN) begin
      other_rst_r <= !fw_req_i.ext_rst_release;
      // PLL enabled only after the DDR configuration is done
      if (fw_req_i.ddr_cfg_done && fw_req_i.mirror_pll_en) begin
        mlink_pd_r <= 1'b0;
      end
      // Dividers leave reset only once rates are set on a running PLL
      if (!mlink_pd_r && fw_req_i.mirror_rate_set && fw_req_i.div_rst_release) begin
        div_rst_r <= 1'b0;
      end
      mclk_en_r <= !div_rst_r;
      // External resets follow enabled clocks
      if (mclk_en_r && fw_req_i.ext_rst_release) begin
        ext_rst_r <= 1'b0;
      end
      // LVDS leaves reset only with power confirmed
      if (fw_req_i.lvds_power_ok && fw_req_i.lvds_rst_release) begin
        lvds_pd_r <= 1'b0;
        lvds_rst_r <= 1'b0;
      end
      lvds_oe_r <= !lvds_rst_r;
    end
  end

  // General I/O enables
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !sense_s || !run_or_park || sys_rst) begin
      io_oe_r <= 1'b0;
      gpio_oe_r <= '0;
    end else begin
      io_oe_r <= 1'b1;
      gpio_oe_r <= '0; // GPIO defaults to input after reset
    end
  end

  // Output carrier built from the individual flops
  assign ctl_r = '{
    primary_pll_rst: pll_rst_r,
    cpu_rst: cpu_rst_r,
    periph_rst: periph_rst_r,
    other_rst: other_rst_r,
    mirror_link_pll_pd: mlink_pd_r,
    mirror_div_rst: div_rst_r,
    mirror_clk_en: mclk_en_r,
    lvds_pd: lvds_pd_r,
    lvds_rst: lvds_rst_r,
    lvds_oe: lvds_oe_r,
    ext_rst: ext_rst_r,
    io_oe: io_oe_r,
    boot_from_flash: boot_flash_r,
    cpu_full_rate: full_rate_r
  };

  assign ctl_o = ctl_r;
  assign park_req_o = park_req_r;
  assign gpio_oe_o = gpio_oe_r;

  // Assertions
  a_sense_low_tri: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !sense_s |=> !ctl_r.io_oe && gpio_oe_r == '0 && ctl_r.cpu_rst)
    else $error("I/O driven while sense low");
  a_pll_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
    sense_rise && state_r == prs_pkg::PRS_OFF |=> ##1 !ctl_r.primary_pll_rst)
    else $error("Primary PLL not released on sense edge");
  a_delay_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_r == prs_pkg::PRS_PLL_WAIT |-> ctl_r.cpu_rst)
    else $error("Processor released during delay");
  a_delay_end: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_r == prs_pkg::PRS_PLL_WAIT && cnt_r == CNT_W'(SENSE_DELAY - 1) && sense_s
    |=> state_r == prs_pkg::PRS_SYSRST)
    else $error("Delay expiry missed");
  a_pll_kept: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_r == prs_pkg::PRS_SYSRST && $past(state_r) == prs_pkg::PRS_SYSRST
    && $past(sense_s, 2) |-> !ctl_r.primary_pll_rst)
    else $error("Primary PLL reset on warm reset");
  a_mirror_pd: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !$past(run_or_park) |-> ctl_r.mirror_link_pll_pd
    && !ctl_r.mirror_clk_en && ctl_r.lvds_rst && !ctl_r.lvds_oe)
    else $error("Mirror link active outside run");
  a_ext_order: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(ctl_r.ext_rst) |-> $past(ctl_r.mirror_clk_en))
    else $error("External reset released before clocks");
  a_lvds_power: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(ctl_r.lvds_rst) |-> $past(fw_req_i.lvds_power_ok))
    else $error("LVDS released without power");
  a_park_first: assert property (@(posedge core_clk_i) disable iff (srst_i)
    warn_fall && sense_s |=> state_r == prs_pkg::PRS_PARK ##1 park_req_r || !sense_s)
    else $error("Warning did not park first");
  a_wdt_reset: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_r == prs_pkg::PRS_RUN && watchdog_timeout_i && !warn_fall && sense_s
    |=> ##1 ctl_r.cpu_rst && ctl_r.ext_rst)
    else $error("Watchdog did not reset");

  a_park_cpu_run: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $past(state_r) == prs_pkg::PRS_PARK && $past(sense_s) |-> !ctl_r.cpu_rst)
    else $error("Processor reset before park finished");

  c_boot: cover property (@(posedge core_clk_i) $fell(ctl_r.cpu_rst));
  c_wdt: cover property (@(posedge core_clk_i) state_r == prs_pkg::PRS_RUN && watchdog_timeout_i);
  c_park_done: cover property (@(posedge core_clk_i) state_r == prs_pkg::PRS_PARK && park_done_i);
  c_park: cover property (@(posedge core_clk_i) state_r == prs_pkg::PRS_PARK);
  c_ext_rel: cover property (@(posedge core_clk_i) $fell(ctl_r.ext_rst));

endmodule

// ==== prs_pkg.sv ====
// Package for the power-on reset sequencer: timing, states and carriers
package prs_pkg;

  // Post-sense delay in microseconds and clock period in picoseconds
  localparam int unsigned SENSE_DELAY_US = 60000;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam longint unsigned SENSE_DELAY_CYC_L =
    (longint'(SENSE_DELAY_US) * 64'd1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SENSE_DELAY_CYC = int'(SENSE_DELAY_CYC_L);

  // Cycles allowed for the mirror park handshake before reset is forced
  localparam int unsigned PARK_TIMEOUT_CYC = 1024;

  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  // Width of the general-purpose pin group
  localparam int unsigned GPIO_W = 9;

  // Reset value of every active-high reset output
  localparam logic RST_ASSERTED = 1'b1;

  typedef enum logic [2:0] {
    PRS_OFF,
    PRS_PLL_WAIT,
    PRS_RUN,
    PRS_PARK,
    PRS_SYSRST
  } prs_state_t;

  // Firmware release requests, steady levels
  typedef struct packed {
    logic ddr_cfg_done;
    logic mirror_pll_en;
    logic mirror_rate_set;
    logic div_rst_release;
    logic ext_rst_release;
    logic lvds_rst_release;
    logic lvds_power_ok;
  } prs_fw_req_t;

  // Reset and enable outputs
  typedef struct packed {
    logic primary_pll_rst;
    logic cpu_rst;
    logic periph_rst;
    logic other_rst;
    logic mirror_link_pll_pd;
    logic mirror_div_rst;
    logic mirror_clk_en;
    logic lvds_pd;
    logic lvds_rst;
    logic lvds_oe;
    logic ext_rst;
    logic io_oe;
    logic boot_from_flash;
    logic cpu_full_rate;
  } prs_ctl_t;

endpackage

// ==== prs_sync.sv ====
// Two-flop synchroniser for a group of asynchronous levels
module prs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Two stages, first read only by the second
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// ==== prs_power_mon.sv ====
// Power monitor model: raises sense only after the supplies settle
module prs_power_mon #(
  parameter int unsigned SETTLE_CYC = 10
) (
  // Clock
  input wire logic core_clk_i,
  // Supply conditions
  input wire logic supplies_up_i,
  input wire logic brownout_i,
  // Monitor pins
  output logic power_on_sense_o,
  output logic supply_ok_warning_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned settle_r = 0;
  initial power_on_sense_o = 1'b0;
  initial supply_ok_warning_o = 1'b0;
  always @(posedge core_clk_i) begin
    if (!supplies_up_i) begin
      settle_r <= 0;
      power_on_sense_o <= 1'b0;
    end else if (settle_r < SETTLE_CYC) begin
      settle_r <= settle_r + 1;
    end else begin
      power_on_sense_o <= 1'b1;
    end
  end
  always @(posedge core_clk_i) begin
    supply_ok_warning_o <= supplies_up_i && !brownout_i;
  end
endmodule

// ==== prs_top_bench.sv ====
// Self-checking bench for the power-on reset sequencer
module prs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SD = 20;
  localparam int unsigned PT = 8;
  localparam logic [13:0] CTL_OFF = 14'h3F6B;
  localparam logic [13:0] CTL_WAIT = 14'h1F6B;
  localparam logic [13:0] CTL_RUN = 14'h076B;
  localparam logic [13:0] M_ALL = 14'h3FFF;
  localparam logic [13:0] M_NOIO = 14'h3FFB;
  typedef struct packed {
    logic [6:0] fw;
    logic [13:0] ctl;
  } prs_row_t;
  prs_row_t rows [6] = '{'{7'h00, 14'h076B}, '{7'h04, 14'h036B}, '{7'h64, 14'h016B},
    '{7'h7C, 14'h00E3}, '{7'h7E, 14'h00E3}, '{7'h7F, 14'h0093}};
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic supplies_up = 1'b0;
  logic brownout = 1'b0;
  logic watchdog = 1'b0;
  logic park_done = 1'b0;
  prs_pkg::prs_fw_req_t fw_req = '0;
  logic sense;
  logic warn;
  prs_pkg::prs_ctl_t ctl;
  logic [13:0] ctl_v;
  logic park_req;
  logic [prs_pkg::GPIO_W-1:0] gpio_oe;
  int fail_count = 0;
  int n_compared = 0;
  assign ctl_v = ctl;

  always #2 core_clk_i = ~core_clk_i;

  prs_power_mon mon_u (.core_clk_i(core_clk_i), .supplies_up_i(supplies_up),
    .brownout_i(brownout), .power_on_sense_o(sense), .supply_ok_warning_o(warn));

  prs_top #(.SENSE_DELAY(SD), .PARK_TIMEOUT(PT)) dut_u (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .power_on_sense_i(sense), .supply_ok_warning_i(warn),
    .watchdog_timeout_i(watchdog), .park_done_i(park_done), .fw_req_i(fw_req),
    .ctl_o(ctl), .park_req_o(park_req), .gpio_oe_o(gpio_oe));

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic chk_ctl(input string what, input logic [13:0] exp, input logic [13:0] m);
    n_compared++;
    if ((ctl_v & m) !== (exp & m)) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp & m, ctl_v & m);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Bounded wait: sel 0 for sense high, 1 for processor reset released
  task automatic wait_until(input int sel, input int lim);
    int k;
    k = 0;
    while (!(sel == 0 ? sense === 1'b1 : ctl.cpu_rst === 1'b0)) begin
      step(1);
      k++;
      if (k > lim) begin
        fail_count++;
        $display("[ERR] wait %0d expected done seen timeout", sel);
        final_report();
      end
    end
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    srst_i <= 1'b0;
    step(1);
    chk_ctl("reset state", CTL_OFF, M_ALL);
    chk_bit("gpio oe", 1'b0, |gpio_oe);
    @(posedge core_clk_i);
    supplies_up <= 1'b1;
    step(5);
    chk_ctl("sense low", CTL_OFF, M_ALL);
    wait_until(0, 30);
    step(6);
    chk_ctl("pll released", CTL_WAIT, M_NOIO);
    step(SD - 2);
    chk_ctl("delay held", CTL_WAIT, M_NOIO);
    wait_until(1, 20);
    step(2);
    chk_ctl("boot state", CTL_RUN, M_NOIO);
    chk_bit("io enabled", 1'b1, ctl.io_oe);
    $display("Test power-up done");
    foreach (rows[i]) begin
      @(posedge core_clk_i);
      fw_req <= rows[i].fw;
      step(4);
      chk_ctl("bring-up row", rows[i].ctl, M_NOIO);
    end
    $display("Test bring-up table done");
    @(posedge core_clk_i);
    watchdog <= 1'b1;
    fw_req <= '0;
    @(posedge core_clk_i);
    watchdog <= 1'b0;
    step(8);
    chk_ctl("after watchdog", CTL_RUN, M_NOIO);
    $display("Test watchdog done");
    @(posedge core_clk_i);
    fw_req <= 7'h7F;
    step(4);
    @(posedge core_clk_i);
    brownout <= 1'b1;
    fw_req <= '0;
    step(6);
    chk_bit("park request", 1'b1, park_req);
    chk_bit("cpu reset while parking", 1'b0, ctl.cpu_rst);
    chk_bit("io kept while parking", 1'b1, ctl.io_oe);
    chk_ctl("link kept while parking", 14'h0493, M_NOIO);
    step(PT + 4);
    chk_bit("park timeout", 1'b0, park_req);
    chk_ctl("warm reset held", CTL_WAIT, M_NOIO);
    chk_bit("io off in warm reset", 1'b0, ctl.io_oe);
    @(posedge core_clk_i);
    brownout <= 1'b0;
    step(10);
    chk_ctl("after warning", CTL_RUN, M_NOIO);
    @(posedge core_clk_i);
    brownout <= 1'b1;
    step(6);
    chk_bit("park request again", 1'b1, park_req);
    @(posedge core_clk_i);
    park_done <= 1'b1;
    step(3);
    chk_bit("park done ends park", 1'b0, park_req);
    chk_bit("cpu reset after park", 1'b1, ctl.cpu_rst);
    @(posedge core_clk_i);
    park_done <= 1'b0;
    brownout <= 1'b0;
    step(10);
    $display("Test warning done");
    @(posedge core_clk_i);
    supplies_up <= 1'b0;
    step(6);
    chk_ctl("sense lost", CTL_OFF, M_ALL);
    chk_bit("gpio oe off", 1'b0, |gpio_oe);
    @(posedge core_clk_i);
    supplies_up <= 1'b1;
    wait_until(0, 30);
    step(6);
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    step(2);
    chk_ctl("mid-run reset", CTL_OFF, M_ALL);
    @(posedge core_clk_i);
    srst_i <= 1'b0;
    step(2);
    $display("Test sense loss and reset done");
    final_report();
  end
endmodule
